// [rtl/sccmd_params.svh]
// register offsets, field positions, reset values and codes for the command decoder
// assumes inclusion by bare name from the design files
`ifndef SCCMD_PARAMS_SVH
`define SCCMD_PARAMS_SVH
`define SCCMD_ADDR_CMD 4'h0
`define SCCMD_ADDR_CTRL 4'h4
`define SCCMD_ADDR_STAT 4'h8
`define SCCMD_ADDR_PTR 4'hc
`define SCCMD_CRC_HI 7
`define SCCMD_CRC_LO 6
`define SCCMD_CMD_HI 5
`define SCCMD_CMD_LO 3
`define SCCMD_PTR_HI 2
`define SCCMD_PTR_LO 0
`define SCCMD_BANK_OFS 4'h8
`define SCCMD_CTRL_RST 8'h00
`define SCCMD_RESP_OKAY 2'h0
`define SCCMD_RESP_SLVERR 2'h2
`define SCCMD_ABORT_ONES 4'hd
`endif

// [rtl/sccmd_pkg.sv]
// types for the command register decoder
// assumes the params header for numeric values
package sccmd_pkg;
  // crc reset field codes
  typedef enum logic [1:0] {
    sccmd_crc_null = 2'h0,
    sccmd_crc_rx = 2'h1,
    sccmd_crc_tx = 2'h2,
    sccmd_crc_msgend = 2'h3
  } sccmd_crc_t;
  // command field codes
  typedef enum logic [2:0] {
    sccmd_cmd_null = 3'h0,
    sccmd_cmd_high = 3'h1,
    sccmd_cmd_ext = 3'h2,
    sccmd_cmd_abort = 3'h3,
    sccmd_cmd_rxnext = 3'h4,
    sccmd_cmd_txpend = 3'h5,
    sccmd_cmd_err = 3'h6,
    sccmd_cmd_svc = 3'h7
  } sccmd_cmd_t;
  // axi write slave states, one-hot
  typedef enum logic [2:0] {
    sccmd_w_idle = 3'h1,
    sccmd_w_exec = 3'h2,
    sccmd_w_resp = 3'h4
  } sccmd_wst_t;
endpackage : sccmd_pkg

// [rtl/sccmd_pulse.sv]
// one-cycle registered pulse stage for a decoded command strobe
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ns
module sccmd_pulse (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  output logic pulse_ff
);
  // registered strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= fire;
    end
  end
endmodule : sccmd_pulse

// [rtl/sccmd_top.sv]
// command register decoder of one serial channel, behind an axi4-lite slave
// assumes the surrounding channel logic consumes the strobes and drives the status inputs
//
// Summary of operation
// - crc code 00 does nothing
// - crc code 01 resets receive crc
// - receiver disable also resets receive crc
// - sdlc hunt or flag resets receive crc
// - crc code 10 resets transmit crc
// - crc code 11 clears underrun latch
// - sdlc underrun with clear latch and abort on underrun set sends abort then flag
// - crc start sets underrun latch
// - latch clear ignored while transmitter disabled
// - disabled clear raises external status interrupt when none is pending or the same byte rearms
// - command 000 does nothing
// - command 001 adds eight to pointer
// - command 010 unlatches status, rearms interrupts
// - persisting queued change interrupts again after rearm
// - command 011 sends abort, empties buffer
// - command 100 rearms first character interrupt
// - command 101 clears transmit interrupt pending
// - command 110 clears receive error bits
// - error reset before read discards character
// - command 111 clears highest under service
// - low three bits select register
// - frame count readable only in enhanced mode
`timescale 1ns/1ns
`include "sccmd_params.svh"
module sccmd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic channel_reset, // channel reset pulse
  input wire logic rx_enabled, // receiver enable level
  input wire logic tx_enabled, // transmitter enable level
  input wire logic rx_hunt, // receiver hunting level
  input wire logic flag_rcvd, // flag received pulse
  input wire logic tx_underrun, // underrun pulse
  input wire logic crc_tx_start, // crc transmission start pulse
  input wire logic ext_status_in, // raw external status level
  input wire logic ext_irq_pending, // external status interrupt pending
  input wire logic reg_access, // host accessed selected register pulse
  output logic rx_crc_reset_ff, // receive crc init pulse
  output logic tx_crc_reset_ff, // transmit crc init pulse
  output logic append_crc_ff, // append crc on underrun pulse
  output logic send_abort_ff, // send abort pulse
  output logic abort_then_flag_ff, // abort then flag pulse
  output logic tx_buf_flush_ff, // empty transmit buffer pulse
  output logic ext_irq_ff, // external status interrupt request pulse
  output logic rx_next_arm_ff, // first character rearm pulse
  output logic tx_pend_clr_ff, // transmit pending clear pulse
  output logic err_reset_ff, // error reset pulse
  output logic svc_clr_ff, // highest under service clear pulse
  output logic [3:0] reg_ptr_ff, // register pointer
  output logic frame_count_visible_ff, // frame count registers readable
  output logic msgend_latch_ff // underrun end of message latch
);
  sccmd_pkg::sccmd_wst_t wst_ff; // write state
  logic [7:0] cmd_ff; // captured command byte
  logic [7:0] ctrl_ff; // control: b0 sdlc, b1 abort on underrun, b2 enhanced, b3 first char
  logic status_latched_ff; // status frozen value
  logic status_hold_ff; // status latched flag
  logic queued_ff; // a second change is queued
  logic cmd_go; // command executes this cycle
  logic ext_rearm; // rearm decoded
  logic msgend_clr_cmd; // latch clear decoded
  logic disabled_clear; // latch clear while tx disabled
  logic ext_change; // status differs from frozen value
  logic [31:0] rd_word; // read mux
  sccmd_pkg::sccmd_crc_t crc_code; // crc field
  sccmd_pkg::sccmd_cmd_t cmd_code; // command field

  assign crc_code = sccmd_pkg::sccmd_crc_t'(cmd_ff[`SCCMD_CRC_HI:`SCCMD_CRC_LO]);
  assign cmd_code = sccmd_pkg::sccmd_cmd_t'(cmd_ff[`SCCMD_CMD_HI:`SCCMD_CMD_LO]);
  assign cmd_go = (wst_ff == sccmd_pkg::sccmd_w_exec);
  assign ext_rearm = cmd_go && (cmd_code == sccmd_pkg::sccmd_cmd_ext);
  assign msgend_clr_cmd = cmd_go && (crc_code == sccmd_pkg::sccmd_crc_msgend);
  assign disabled_clear = msgend_clr_cmd && !tx_enabled;
  assign ext_change = ext_status_in != status_latched_ff;

  // write channel: take address and data in either order, execute, respond
  logic aw_got_ff; // address held
  logic w_got_ff; // data held
  logic aw_ok_ff; // byte 0 write strobe held with the data
  logic [3:0] aw_addr_ff; // held address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_ff <= sccmd_pkg::sccmd_w_idle;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_ok_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      cmd_ff <= 8'h00;
      ctrl_ff <= `SCCMD_CTRL_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCCMD_RESP_OKAY;
    end else begin
      case (wst_ff)
        sccmd_pkg::sccmd_w_idle: begin
          s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            cmd_ff <= s_axi_wdata[7:0];
            aw_ok_ff <= s_axi_wstrb[0];
          end
          if (aw_got_ff && w_got_ff) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (aw_addr_ff == `SCCMD_ADDR_CMD && aw_ok_ff) begin
              wst_ff <= sccmd_pkg::sccmd_w_exec;
            end else begin
              // control register write or refusal
              if (aw_addr_ff == `SCCMD_ADDR_CTRL && aw_ok_ff) begin
                ctrl_ff <= cmd_ff;
              end
              s_axi_bresp <= ((aw_addr_ff == `SCCMD_ADDR_CTRL) && aw_ok_ff) ?
                             `SCCMD_RESP_OKAY : `SCCMD_RESP_SLVERR;
              s_axi_bvalid <= 1'b1;
              wst_ff <= sccmd_pkg::sccmd_w_resp;
            end
          end
        end
        sccmd_pkg::sccmd_w_exec: begin
          s_axi_bresp <= `SCCMD_RESP_OKAY;
          s_axi_bvalid <= 1'b1;
          wst_ff <= sccmd_pkg::sccmd_w_resp;
        end
        sccmd_pkg::sccmd_w_resp: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wst_ff <= sccmd_pkg::sccmd_w_idle;
          end
        end
        default: begin
          wst_ff <= sccmd_pkg::sccmd_w_idle;
        end
      endcase
    end
  end

  // receive and transmit crc strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_crc_reset_ff <= 1'b0;
      tx_crc_reset_ff <= 1'b0;
    end else begin
      // no action for the null crc code
      rx_crc_reset_ff <= (cmd_go && crc_code == sccmd_pkg::sccmd_crc_rx)
                         || !rx_enabled
                         || (ctrl_ff[0] && (rx_hunt || flag_rcvd));
      // channel reset not included on purpose
      tx_crc_reset_ff <= cmd_go && crc_code == sccmd_pkg::sccmd_crc_tx;
    end
  end

  // underrun end of message latch and underrun outcomes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msgend_latch_ff <= 1'b1;
      append_crc_ff <= 1'b0;
      abort_then_flag_ff <= 1'b0;
    end else begin
      append_crc_ff <= tx_underrun && !msgend_latch_ff && !(ctrl_ff[0] && ctrl_ff[1]);
      abort_then_flag_ff <= tx_underrun && !msgend_latch_ff && ctrl_ff[0] && ctrl_ff[1];
      // set wins over clear
      if (crc_tx_start || (cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_abort)) begin
        msgend_latch_ff <= 1'b1;
      end else if (msgend_clr_cmd && tx_enabled) begin
        // a disabled transmitter leaves the latch as it is
        msgend_latch_ff <= 1'b0;
      end
    end
  end

  // external status latching, queue and interrupt request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_latched_ff <= 1'b0;
      status_hold_ff <= 1'b0;
      queued_ff <= 1'b0;
      ext_irq_ff <= 1'b0;
    end else begin
      ext_irq_ff <= 1'b0;
      if (!status_hold_ff) begin
        status_latched_ff <= ext_status_in;
        if (ext_change) begin
          status_hold_ff <= 1'b1;
          ext_irq_ff <= 1'b1;
        end
      end else if (ext_rearm) begin
        // queued change only counts if it still stands
        status_hold_ff <= queued_ff && ext_change;
        ext_irq_ff <= queued_ff && ext_change;
        status_latched_ff <= ext_status_in;
        queued_ff <= 1'b0;
      end else if (ext_change) begin
        queued_ff <= 1'b1;
      end
      // last, so a rearm in the same byte cannot mask this request
      if (disabled_clear && (!ext_irq_pending || ext_rearm)) begin
        ext_irq_ff <= 1'b1;
      end
    end
  end

  // command field strobes through the pulse stages
  sccmd_pulse u_abort (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_abort), .pulse_ff(send_abort_ff));
  sccmd_pulse u_flush (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_abort), .pulse_ff(tx_buf_flush_ff));
  sccmd_pulse u_rxnext (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_rxnext && ctrl_ff[3]),
    .pulse_ff(rx_next_arm_ff));
  sccmd_pulse u_txpend (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_txpend),
    .pulse_ff(tx_pend_clr_ff));
  sccmd_pulse u_err (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_err),
    .pulse_ff(err_reset_ff));
  sccmd_pulse u_svc (.aclk(aclk), .aresetn(aresetn),
    .fire(cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_svc),
    .pulse_ff(svc_clr_ff));

  // register pointer and frame count visibility
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_ptr_ff <= 4'h0;
      frame_count_visible_ff <= 1'b0;
    end else begin
      frame_count_visible_ff <= ctrl_ff[2];
      // channel reset outranks any pointer load
      if (channel_reset) begin
        reg_ptr_ff <= 4'h0;
      end else if (cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_high) begin
        reg_ptr_ff <= `SCCMD_BANK_OFS + {1'b0, cmd_ff[`SCCMD_PTR_HI:`SCCMD_PTR_LO]};
      end else if (cmd_go) begin
        // every code but 001 leaves only the pointer bits
        reg_ptr_ff <= {1'b0, cmd_ff[`SCCMD_PTR_HI:`SCCMD_PTR_LO]};
      end else if (reg_access) begin
        reg_ptr_ff <= 4'h0;
      end
    end
  end

  // read channel, single outstanding read
  // unmapped or write-only offsets answer with an error code and zero data
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `SCCMD_ADDR_CTRL: rd_word = {24'h000000, ctrl_ff};
      `SCCMD_ADDR_STAT: rd_word = {27'h0000000, queued_ff, status_hold_ff,
                                   status_latched_ff, frame_count_visible_ff, msgend_latch_ff};
      `SCCMD_ADDR_PTR: rd_word = {28'h0000000, reg_ptr_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SCCMD_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (s_axi_araddr == `SCCMD_ADDR_CTRL || s_axi_araddr == `SCCMD_ADDR_STAT ||
                      s_axi_araddr == `SCCMD_ADDR_PTR) ? `SCCMD_RESP_OKAY : `SCCMD_RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // checks
  a_crc_rx_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && crc_code == sccmd_pkg::sccmd_crc_rx) |=> rx_crc_reset_ff)
    else $error("rx crc reset missing");
  a_crc_rx_dis: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_enabled |=> rx_crc_reset_ff)
    else $error("rx crc not reset on disable");
  a_crc_tx_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_crc_reset_ff |-> $past(cmd_ff[7:6]) == 2'h2)
    else $error("spurious tx crc reset");
  a_msgend_set: assert property (@(posedge aclk) disable iff (!aresetn)
    crc_tx_start |=> msgend_latch_ff)
    else $error("latch not set at crc start");
  a_msgend_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (disabled_clear && msgend_latch_ff) |=> msgend_latch_ff)
    else $error("latch cleared while disabled");
  a_ext_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    (disabled_clear && !ext_irq_pending) |=> ext_irq_ff)
    else $error("no ext interrupt on disabled clear");
  a_ptr_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_high && !channel_reset) |=> reg_ptr_ff[3])
    else $error("pointer high missing");
  a_abort_msgend: assert property (@(posedge aclk) disable iff (!aresetn)
    send_abort_ff |-> msgend_latch_ff && tx_buf_flush_ff)
    else $error("abort without latch set");
  a_svc_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_go && cmd_code == sccmd_pkg::sccmd_cmd_svc) |=> svc_clr_ff ##1 !svc_clr_ff)
    else $error("in service clear not one pulse");
  a_ptr_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (reg_access && !cmd_go && !channel_reset) |=> reg_ptr_ff == 4'h0)
    else $error("pointer not returned to zero");
  c_cmd_write: cover property (@(posedge aclk) disable iff (!aresetn) cmd_go);
  c_rearm_queue: cover property (@(posedge aclk) disable iff (!aresetn) ext_rearm && queued_ff);
  c_append: cover property (@(posedge aclk) disable iff (!aresetn) append_crc_ff);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  // latch clear with rearm while the transmitter is off
  c_dis_rearm: cover property (@(posedge aclk) disable iff (!aresetn) disabled_clear && ext_rearm);
endmodule : sccmd_top

// [verif/sccmd_host.sv]
// host model: axi4-lite master issuing one register access at a time
// assumes one rising-edge clock; outputs move only right after an edge
`timescale 1ns/1ns
module sccmd_host (
  input wire logic aclk,
  output logic [3:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [3:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // write: address and data offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        got = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask : wr
  // read: address held until taken, rready held until rvalid seen
  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask : rd
endmodule : sccmd_host

// [verif/test_serial_ctrl_command_register.sv]
// self-checking bench for the command decoder, host model on the axi side
// assumes outputs are registered; pulses are counted over a short window
`timescale 1ns/1ns
`include "sccmd_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_serial_ctrl_command_register;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] awaddr, wstrb, araddr, reg_ptr_ff;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic channel_reset = 0, rx_enabled = 1, tx_enabled = 1, rx_hunt = 0, flag_rcvd = 0;
  logic tx_underrun = 0, crc_tx_start = 0, ext_status_in = 0, ext_irq_pending = 0;
  logic reg_access = 0;
  logic rx_crc_reset_ff, tx_crc_reset_ff, append_crc_ff, send_abort_ff, abort_then_flag_ff;
  logic tx_buf_flush_ff, ext_irq_ff, rx_next_arm_ff, tx_pend_clr_ff, err_reset_ff, svc_clr_ff;
  logic frame_count_visible_ff, msgend_latch_ff;
  logic [10:0] strb; // all strobes, crc reset at the top
  int cnt [11]; // cycles each strobe was seen high
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  assign strb = {rx_crc_reset_ff, tx_crc_reset_ff, append_crc_ff, send_abort_ff,
    abort_then_flag_ff, tx_buf_flush_ff, ext_irq_ff, rx_next_arm_ff, tx_pend_clr_ff,
    err_reset_ff, svc_clr_ff};
  always #10 aclk = ~aclk;
  sccmd_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .channel_reset(channel_reset), .rx_enabled(rx_enabled),
    .tx_enabled(tx_enabled), .rx_hunt(rx_hunt), .flag_rcvd(flag_rcvd),
    .tx_underrun(tx_underrun), .crc_tx_start(crc_tx_start), .ext_status_in(ext_status_in),
    .ext_irq_pending(ext_irq_pending), .reg_access(reg_access),
    .rx_crc_reset_ff(rx_crc_reset_ff), .tx_crc_reset_ff(tx_crc_reset_ff),
    .append_crc_ff(append_crc_ff), .send_abort_ff(send_abort_ff),
    .abort_then_flag_ff(abort_then_flag_ff), .tx_buf_flush_ff(tx_buf_flush_ff),
    .ext_irq_ff(ext_irq_ff), .rx_next_arm_ff(rx_next_arm_ff), .tx_pend_clr_ff(tx_pend_clr_ff),
    .err_reset_ff(err_reset_ff), .svc_clr_ff(svc_clr_ff), .reg_ptr_ff(reg_ptr_ff),
    .frame_count_visible_ff(frame_count_visible_ff), .msgend_latch_ff(msgend_latch_ff));
  sccmd_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // strobe counters and hang guard
  always @(posedge aclk) begin
    for (int i = 0; i < 11; i++) if (strb[i] === 1'b1) cnt[i]++;
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // counters cleared away from the edge
  task clr();
    @(negedge aclk);
    for (int i = 0; i < 11; i++) cnt[i] = 0;
  endtask : clr
  // each strobe must have fired once or never; more shows as unknown
  task expect_cnt(input logic [10:0] e, input string nm);
    logic [10:0] g;
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    for (int i = 0; i < 11; i++) g[i] = (cnt[i] == 0) ? 1'b0 : ((cnt[i] == 1) ? 1'b1 : 1'bx);
    `CHK(nm, e, g)
  endtask : expect_cnt
  task cmd(input logic [7:0] b);
    clr();
    u_host.wr(`SCCMD_ADDR_CMD, {24'h0, b}, 4'hf, rd_r);
  endtask : cmd
  task ctrl(input logic [7:0] v);
    u_host.wr(`SCCMD_ADDR_CTRL, {24'h0, v}, 4'hf, rd_r);
  endtask : ctrl
  task t_reset();
    @(negedge aclk);
    `CHK("latch at reset", 1'b1, msgend_latch_ff)
    `CHK("pointer", 4'h0, reg_ptr_ff)
    `CHK("strobes", 11'h0, strb)
    u_host.rd(`SCCMD_ADDR_STAT, rd_d, rd_r);
    `CHK("status read", 32'h1, rd_d)
    $display("reset test done");
  endtask : t_reset
  // status change, queued change, reverting change
  task t_ext();
    clr();
    @(posedge aclk) ext_status_in <= 1'b1;
    expect_cnt(11'h010, "first change");
    clr();
    @(posedge aclk) ext_status_in <= 1'b0;
    expect_cnt(11'h0, "held change");
    cmd(8'h10);
    expect_cnt(11'h010, "queued persists");
    cmd(8'h10);
    expect_cnt(11'h0, "nothing queued");
    clr();
    @(posedge aclk) ext_status_in <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_status_in <= 1'b0;
    @(posedge aclk) ext_status_in <= 1'b1;
    cmd(8'h10);
    expect_cnt(11'h0, "queued reverted");
    $display("ext status test done");
  endtask : t_ext
  task t_crc();
    static logic [10:0] ce [4] = '{11'h0, 11'h400, 11'h200, 11'h0};
    for (int c = 0; c < 4; c++) begin
      cmd({c[1:0], 6'h0});
      expect_cnt(ce[c], "crc code");
    end
    `CHK("latch cleared", 1'b0, msgend_latch_ff)
    $display("crc code test done");
  endtask : t_crc
  // every command code, pointer 5; error reset follows a data read in real use
  task t_cmds();
    static logic [10:0] me [8] = '{11'h0, 11'h0, 11'h0, 11'h0a0, 11'h008, 11'h004, 11'h002, 11'h001};
    ctrl(8'h08);
    for (int k = 0; k < 8; k++) begin
      cmd({2'b00, k[2:0], 3'h5});
      expect_cnt(me[k], "command code");
      `CHK("pointer", (k == 1) ? 4'hd : 4'h5, reg_ptr_ff)
      if (k == 3) `CHK("abort sets latch", 1'b1, msgend_latch_ff)
    end
    u_host.rd(`SCCMD_ADDR_PTR, rd_d, rd_r);
    `CHK("pointer read", 32'h5, rd_d)
    @(posedge aclk) reg_access <= 1'b1;
    @(posedge aclk) reg_access <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("pointer after access", 4'h0, reg_ptr_ff)
    cmd(8'h05);
    @(posedge aclk) channel_reset <= 1'b1;
    @(posedge aclk) channel_reset <= 1'b0;
    expect_cnt(11'h0, "channel reset");
    `CHK("pointer after reset", 4'h0, reg_ptr_ff)
    ctrl(8'h00);
    $display("command test done");
  endtask : t_cmds
  task t_latch();
    @(posedge aclk) tx_enabled <= 1'b0;
    cmd(8'hc0);
    expect_cnt(11'h010, "disabled clear irq");
    `CHK("latch kept", 1'b1, msgend_latch_ff)
    @(posedge aclk) ext_irq_pending <= 1'b1;
    cmd(8'hc0);
    expect_cnt(11'h0, "pending clear no irq");
    cmd(8'hd0);
    expect_cnt(11'h010, "rearm clear irq");
    @(posedge aclk) ext_irq_pending <= 1'b0;
    @(posedge aclk) tx_enabled <= 1'b1;
    cmd(8'hc0);
    clr();
    @(posedge aclk) tx_underrun <= 1'b1;
    @(posedge aclk) tx_underrun <= 1'b0;
    expect_cnt(11'h100, "append crc");
    @(posedge aclk) crc_tx_start <= 1'b1;
    @(posedge aclk) crc_tx_start <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("crc start sets", 1'b1, msgend_latch_ff)
    ctrl(8'h03);
    cmd(8'hc0);
    clr();
    @(posedge aclk) tx_underrun <= 1'b1;
    @(posedge aclk) tx_underrun <= 1'b0;
    expect_cnt(11'h040, "abort on underrun");
    ctrl(8'h00);
    $display("latch test done");
  endtask : t_latch
  task t_misc();
    clr();
    @(posedge aclk) rx_enabled <= 1'b0;
    repeat (3) @(posedge aclk);
    rx_enabled <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("rx off crc", 1'b1, cnt[10] > 0)
    ctrl(8'h01);
    clr();
    @(posedge aclk) rx_hunt <= 1'b1;
    repeat (3) @(posedge aclk);
    rx_hunt <= 1'b0;
    @(posedge aclk) flag_rcvd <= 1'b1;
    @(posedge aclk) flag_rcvd <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK("hunt crc", 1'b1, cnt[10] > 3)
    ctrl(8'h04);
    repeat (3) @(posedge aclk);
    `CHK("frame count on", 1'b1, frame_count_visible_ff)
    u_host.rd(`SCCMD_ADDR_CTRL, rd_d, rd_r);
    `CHK("control readback", 32'h4, rd_d)
    `CHK("control read resp", `SCCMD_RESP_OKAY, rd_r)
    ctrl(8'h00);
    repeat (3) @(posedge aclk);
    `CHK("frame count off", 1'b0, frame_count_visible_ff)
    clr();
    u_host.wr(`SCCMD_ADDR_CMD, 32'h50, 4'h0, rd_r);
    `CHK("no strobe lane", `SCCMD_RESP_SLVERR, rd_r)
    u_host.wr(`SCCMD_ADDR_STAT, 32'h50, 4'hf, rd_r);
    `CHK("read only", `SCCMD_RESP_SLVERR, rd_r)
    expect_cnt(11'h0, "refused writes");
    u_host.rd(`SCCMD_ADDR_CMD, rd_d, rd_r);
    `CHK("command reads zero", 32'h0, rd_d)
    `CHK("command read resp", `SCCMD_RESP_SLVERR, rd_r)
    $display("misc test done");
  endtask : t_misc
  task report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // reset, then each scenario in turn
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ext();
    t_crc();
    t_cmds();
    t_latch();
    t_misc();
    report_and_stop();
  end
endmodule : test_serial_ctrl_command_register
